/* logic/field_decoder_consts.vh */
// Constants for the operand size and instruction field decoder
//
// Functional notes
// - Default sizes follow code segment D bit
// - Real and V86 modes force D zero
// - Each size prefix inverts its own default
// - Override lasts for one instruction only
// - Either prefix, any order, same result
// - Prefixes honoured in every operating mode
// - Narrow writes keep upper register bits
// - Width bit: zero byte, one full size
// - Register code from opcode, reg or r/m
// - No width bit: eight full-size registers
// - Width zero: low then high bytes
// - Narrow segment field: ES CS SS DS
// - Wide segment field adds FS, GS
`ifndef FIELD_DECODER_CONSTS_VH
`define FIELD_DECODER_CONSTS_VH

// Prefix byte values (plain defaults, overridable)
`define OSZ_PREFIX   8'h66
`define ASZ_PREFIX   8'h67

// Register code position select
`define POS_OPCODE   2'h0
`define POS_MODRM_REG 2'h1
`define POS_MODRM_RM 2'h2

// Field positions in the bytes
`define OPC_REG_LSB  0
`define MRM_REG_LSB  3
`define MRM_RM_LSB   0
`define HIGH_BYTE_BIT 2

// Operand width codes
`define SZ_BYTE_LO   2'h0
`define SZ_BYTE_HI   2'h1
`define SZ_WORD      2'h2
`define SZ_DWORD     2'h3

// Segment register codes
`define SEG_ES       3'h0
`define SEG_CS       3'h1
`define SEG_SS       3'h2
`define SEG_DS       3'h3
`define SEG_FS       3'h4
`define SEG_GS       3'h5
`define SEG_RSV_LO   3'h6

// Reset values
`define RST_BYTE     8'h00
`define RST_WORD     32'h00000000

`endif

/* logic/operand_size_and_field_decoder.v */
// Operand size resolution and register field decoder
`timescale 1ns/1ps
`include "field_decoder_consts.vh"

module operand_size_and_field_decoder #(
  parameter [7:0] OSZ_CODE = `OSZ_PREFIX,
  parameter [7:0] ASZ_CODE = `ASZ_PREFIX
) (
  input  wire        clk,          // Core clock, 10 MHz
  input  wire        reset_n,      // Async reset, active low
  input  wire        clk_en,       // Freezes all state when low
  input  wire        code_seg_d,   // Code segment default-size bit
  input  wire        real_mode,    // Real address mode
  input  wire        v86_mode,     // V86 mode
  input  wire        byte_valid,   // Instruction byte offered
  input  wire [7:0]  byte_in,      // Instruction byte
  input  wire        other_prefix, // Byte is a non-size prefix
  input  wire        fld_req,      // Field decode request
  input  wire [7:0]  fld_opcode,   // Opcode byte holding reg
  input  wire [7:0]  fld_modrm,    // Mod r/m byte
  input  wire [1:0]  fld_pos,      // Where the reg code sits
  input  wire        fld_w_present, // Width bit exists
  input  wire        fld_w,        // Width bit value
  input  wire        seg_req,      // Segment field decode request
  input  wire        seg_wide,     // Field is the 3-bit form
  input  wire [2:0]  seg_field,    // Segment field bits
  input  wire        wr_req,       // Register write merge request
  input  wire [1:0]  wr_size,      // Width code of the result
  input  wire [31:0] wr_old,       // Current register value
  input  wire [31:0] wr_data,      // Result, low-aligned
  output reg         size_valid_reg, // Opcode seen, sizes valid
  output reg  [7:0]  opcode_reg,   // Opcode that ended prefixes
  output reg         op32_reg,     // Operand size is 32 bits
  output reg         addr32_reg,   // Address size is 32 bits
  output reg         fld_done_reg, // Register decode result
  output reg  [2:0]  gpr_sel_reg,  // Register number
  output reg  [1:0]  gpr_size_reg, // Width code of selection
  output reg         seg_done_reg, // Segment decode result
  output reg  [2:0]  seg_sel_reg,  // Segment register code
  output reg         seg_invalid_reg, // Reserved segment code
  output reg         wr_done_reg,  // Merge result valid
  output reg  [31:0] wr_merged_reg // Value to write back
);

  // ******************************************************
  // Default size
  // ******************************************************
  // Mode inputs win over the D bit; prefixes still apply later
  wire d_eff;
  assign d_eff = code_seg_d & ~real_mode & ~v86_mode;

  // ******************************************************
  // Prefix scanning
  // ******************************************************
  // Sizes are committed only when the opcode byte arrives, so
  // a stalled prefix run never leaks into the current sizes.
  function match_byte;
    input       valid;
    input [7:0] b;
    input [7:0] code;
    begin
      match_byte = valid & (b == code);
    end
  endfunction

  reg        osz_seen_reg;
  reg        asz_seen_reg;
  reg        osz_seen_next;
  reg        asz_seen_next;
  reg        size_valid_next;
  reg  [7:0] opcode_next;
  reg        op32_next;
  reg        addr32_next;
  wire       is_osz;
  wire       is_asz;
  wire       is_opcode;

  assign is_osz    = match_byte(byte_valid, byte_in, OSZ_CODE);
  assign is_asz    = match_byte(byte_valid, byte_in, ASZ_CODE);
  assign is_opcode = byte_valid & ~is_osz & ~is_asz & ~other_prefix;

  always @*
  begin
    osz_seen_next   = osz_seen_reg;
    asz_seen_next   = asz_seen_reg;
    size_valid_next = 1'b0;
    opcode_next     = opcode_reg;
    op32_next       = op32_reg;
    addr32_next     = addr32_reg;
    // Flags only set, so prefix order never matters
    if (is_osz)
    begin
      osz_seen_next = 1'b1;
    end
    if (is_asz)
    begin
      asz_seen_next = 1'b1;
    end
    if (is_opcode)
    begin
      osz_seen_next   = 1'b0;
      asz_seen_next   = 1'b0;
      size_valid_next = 1'b1;
      opcode_next     = byte_in;
      // Toggle works the same in every mode
      op32_next       = d_eff ^ osz_seen_reg;
      addr32_next     = d_eff ^ asz_seen_reg;
    end
  end

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      osz_seen_reg   <= 1'b0;
      asz_seen_reg   <= 1'b0;
      size_valid_reg <= 1'b0;
      opcode_reg     <= `RST_BYTE;
      op32_reg       <= 1'b0;
      addr32_reg     <= 1'b0;
    end
    else if (clk_en)
    begin
      osz_seen_reg   <= osz_seen_next;
      asz_seen_reg   <= asz_seen_next;
      size_valid_reg <= size_valid_next;
      opcode_reg     <= opcode_next;
      op32_reg       <= op32_next;
      addr32_reg     <= addr32_next;
    end
  end

  // ******************************************************
  // Register field decode
  // ******************************************************
  // Sizes from the last opcode; a request must follow
  // size_valid_reg for the matching instruction.
  function [2:0] pick_code;
    input [1:0] pos;
    input [7:0] opc;
    input [7:0] mrm;
    begin
      case (pos)
        `POS_OPCODE:    pick_code = opc[`OPC_REG_LSB +: 3];
        `POS_MODRM_REG: pick_code = mrm[`MRM_REG_LSB +: 3];
        `POS_MODRM_RM:  pick_code = mrm[`MRM_RM_LSB +: 3];
        default:        pick_code = mrm[`MRM_RM_LSB +: 3];
      endcase
    end
  endfunction

  function [1:0] full_size;
    input op32;
    begin
      full_size = op32 ? `SZ_DWORD : `SZ_WORD;
    end
  endfunction

  wire [2:0] reg_code;
  reg        fld_done_next;
  reg  [2:0] gpr_sel_next;
  reg  [1:0] gpr_size_next;

  assign reg_code = pick_code(fld_pos, fld_opcode, fld_modrm);

  // Result holds between requests so a slow consumer can read it late
  always @*
  begin
    fld_done_next = fld_req;
    gpr_sel_next  = gpr_sel_reg;
    gpr_size_next = gpr_size_reg;
    if (fld_req)
    begin
      gpr_sel_next  = reg_code;
      gpr_size_next = full_size(op32_reg);
      if (fld_w_present && !fld_w)
      begin
        // Codes 100..111 are high bytes of the first four
        gpr_sel_next  = {1'b0, reg_code[1:0]};
        gpr_size_next = reg_code[`HIGH_BYTE_BIT] ? `SZ_BYTE_HI
                                                 : `SZ_BYTE_LO;
      end
    end
  end

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fld_done_reg <= 1'b0;
      gpr_sel_reg  <= 3'h0;
      gpr_size_reg <= `SZ_BYTE_LO;
    end
    else if (clk_en)
    begin
      fld_done_reg <= fld_done_next;
      gpr_sel_reg  <= gpr_sel_next;
      gpr_size_reg <= gpr_size_next;
    end
  end

  // ******************************************************
  // Segment field decode
  // ******************************************************
  reg       seg_done_next;
  reg [2:0] seg_sel_next;
  reg       seg_bad_next;

  always @*
  begin
    seg_done_next = seg_req;
    seg_sel_next  = seg_sel_reg;
    seg_bad_next  = seg_invalid_reg;
    if (seg_req && !seg_wide)
    begin
      seg_bad_next = 1'b0;
      case (seg_field[1:0])
        2'h0:    seg_sel_next = `SEG_ES;
        2'h1:    seg_sel_next = `SEG_CS;
        2'h2:    seg_sel_next = `SEG_SS;
        2'h3:    seg_sel_next = `SEG_DS;
        default: seg_sel_next = `SEG_ES;
      endcase
    end
    else if (seg_req && (seg_field >= `SEG_RSV_LO))
    begin
      // ES is named and flagged invalid, so a load cannot use a reserved code
      seg_sel_next = `SEG_ES;
      seg_bad_next = 1'b1;
    end
    else if (seg_req)
    begin
      // Encodings match the wide field numbering directly
      seg_sel_next = seg_field;
      seg_bad_next = 1'b0;
    end
  end

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      seg_done_reg    <= 1'b0;
      seg_sel_reg     <= `SEG_ES;
      seg_invalid_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      seg_done_reg    <= seg_done_next;
      seg_sel_reg     <= seg_sel_next;
      seg_invalid_reg <= seg_bad_next;
    end
  end

  // ******************************************************
  // Narrow write merge
  // ******************************************************
  function [31:0] merge;
    input [1:0]  sz;
    input [31:0] old;
    input [31:0] dat;
    begin
      case (sz)
        `SZ_BYTE_LO: merge = {old[31:8], dat[7:0]};
        `SZ_BYTE_HI: merge = {old[31:16], dat[7:0], old[7:0]};
        `SZ_WORD:    merge = {old[31:16], dat[15:0]};
        `SZ_DWORD:   merge = dat;
        default:     merge = old;
      endcase
    end
  endfunction

  reg        wr_done_next;
  reg [31:0] wr_merged_next;

  // Merging here spares the register file a read-modify cycle
  always @*
  begin
    wr_done_next   = wr_req;
    wr_merged_next = wr_merged_reg;
    if (wr_req)
    begin
      // Upper bits survive any narrow result
      wr_merged_next = merge(wr_size, wr_old, wr_data);
    end
  end

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_done_reg   <= 1'b0;
      wr_merged_reg <= `RST_WORD;
    end
    else if (clk_en)
    begin
      wr_done_reg   <= wr_done_next;
      wr_merged_reg <= wr_merged_next;
    end
  end

endmodule // operand_size_and_field_decoder

/* sim/field_decoder_asserts.sv */
// Checker for the operand size and field decoder
`timescale 1ns/1ps
module field_decoder_asserts (
  input wire        clk,             // Clock
  input wire        reset_n,         // Reset
  input wire        clk_en,          // Run
  input wire        byte_valid,      // Byte
  input wire [7:0]  byte_in,         // Byte
  input wire        other_prefix,    // Prefix
  input wire        fld_req,         // Req
  input wire        fld_w_present,   // W
  input wire        fld_w,           // W
  input wire        seg_req,         // Req
  input wire        seg_wide,        // Wide
  input wire [2:0]  seg_field,       // Code
  input wire        wr_req,          // Req
  input wire [1:0]  wr_size,         // Size
  input wire [31:0] wr_old,          // Old
  input wire        size_valid_reg,  // Out
  input wire        op32_reg,        // Out
  input wire        fld_done_reg,    // Out
  input wire [2:0]  gpr_sel_reg,     // Out
  input wire [1:0]  gpr_size_reg,    // Out
  input wire        seg_done_reg,    // Out
  input wire [2:0]  seg_sel_reg,     // Out
  input wire        seg_invalid_reg, // Out
  input wire [31:0] wr_merged_reg    // Out
);
  // **********
  // Properties
  // **********
  wire opc_take = clk_en & byte_valid & ~other_prefix & (byte_in != 8'h66) & (byte_in != 8'h67);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_size_pulse: assert property (opc_take |=> size_valid_reg)
    else $error("size valid missing");
  chk_fld_pulse: assert property (clk_en && fld_req |=> fld_done_reg)
    else $error("field done missing");
  chk_full_size: assert property (clk_en && fld_req && (!fld_w_present || fld_w)
    |=> gpr_size_reg == {1'b1, $past(op32_reg)}) else $error("full size wrong");
  chk_byte_low: assert property (clk_en && fld_req && fld_w_present && !fld_w
    |=> !gpr_size_reg[1] && !gpr_sel_reg[2]) else $error("byte select wrong");
  chk_seg_pulse: assert property (clk_en && seg_req |=> seg_done_reg)
    else $error("segment done missing");
  chk_seg_narrow: assert property (clk_en && seg_req && !seg_wide
    |=> seg_sel_reg[1:0] == $past(seg_field[1:0]) && !seg_sel_reg[2] && !seg_invalid_reg)
    else $error("narrow segment wrong");
  chk_seg_reserved: assert property (clk_en && seg_req && seg_wide && seg_field[2]
    && seg_field[1] |=> seg_invalid_reg && seg_sel_reg == 3'h0) else $error("reserved code");
  chk_wr_upper: assert property (clk_en && wr_req && wr_size != 2'h3
    |=> wr_merged_reg[31:16] == $past(wr_old[31:16])) else $error("upper bits changed");
  cover property (seg_invalid_reg);
  cover property (fld_done_reg && gpr_size_reg == 2'h1);
  cover property (size_valid_reg && op32_reg);
endmodule // field_decoder_asserts

/* sim/prefetch_feed.sv */
// Model of the prefetch queue that feeds instruction bytes
`timescale 1ns/1ps
module prefetch_feed (
  input  wire        clk,         // Clock
  output logic       byte_valid,  // Byte offered
  output logic [7:0] byte_in,     // Byte
  output logic       other_prefix // Non-size prefix
);
  initial
  begin
    byte_valid = 1'b0;
    byte_in = 8'h00;
    other_prefix = 1'b0;
  end
  // One byte per cycle, prefixes ahead of the opcode
  task send(input logic [7:0] b, input logic o);
    @(negedge clk);
    byte_valid = 1'b1;
    byte_in = b;
    other_prefix = o;
  endtask
  // Released bus shows the inverse so a stale byte cannot pass
  task idle;
    @(negedge clk);
    byte_valid = 1'b0;
    byte_in = ~byte_in;
    other_prefix = 1'b0;
  endtask
endmodule // prefetch_feed

/* sim/tb.sv */
// Testbench for the operand size and field decoder
`timescale 1ns/1ps
module tb;
  logic        clk, reset_n, clk_en, code_seg_d, real_mode, v86_mode, byte_valid, other_prefix;
  logic        fld_req, fld_w_present, fld_w, seg_req, seg_wide, wr_req, size_valid_reg;
  logic        op32_reg, addr32_reg, fld_done_reg, seg_done_reg, seg_invalid_reg, wr_done_reg;
  logic [7:0]  byte_in, fld_opcode, fld_modrm, opcode_reg;
  logic [1:0]  fld_pos, wr_size, gpr_size_reg;
  logic [2:0]  seg_field, gpr_sel_reg, seg_sel_reg;
  logic [31:0] wr_old, wr_data, wr_merged_reg;
  int          fail_count, cmp_count;
  operand_size_and_field_decoder operand_size_and_field_decoder_i (.clk, .reset_n, .clk_en,
    .code_seg_d, .real_mode, .v86_mode, .byte_valid, .byte_in, .other_prefix, .fld_req,
    .fld_opcode, .fld_modrm, .fld_pos, .fld_w_present, .fld_w, .seg_req, .seg_wide, .seg_field,
    .wr_req, .wr_size, .wr_old, .wr_data, .size_valid_reg, .opcode_reg, .op32_reg, .addr32_reg,
    .fld_done_reg, .gpr_sel_reg, .gpr_size_reg, .seg_done_reg, .seg_sel_reg, .seg_invalid_reg,
    .wr_done_reg, .wr_merged_reg);
  prefetch_feed prefetch_feed_i (.clk, .byte_valid, .byte_in, .other_prefix);
  // *****
  // Tasks
  // *****
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Prefix byte 00 means none; a non-size prefix rides along with the first
  task instr(input logic d, rm, vm, input logic [7:0] a, b, input logic eo, ea);
    code_seg_d = d;
    real_mode = rm;
    v86_mode = vm;
    if (a != 8'h00) prefetch_feed_i.send(a, 1'b0);
    if (a != 8'h00) prefetch_feed_i.send(8'h2E, 1'b1);
    if (b != 8'h00) prefetch_feed_i.send(b, 1'b0);
    prefetch_feed_i.send(8'h90, 1'b0);
    prefetch_feed_i.idle;
    chk(size_valid_reg, 1);
    chk(op32_reg, eo);
    chk(addr32_reg, ea);
    chk(opcode_reg, 8'h90);
  endtask
  task fld(input logic [1:0] p, input logic [7:0] o, m, input logic wp, w,
           input logic [2:0] es, input logic [1:0] ez);
    {fld_pos, fld_opcode, fld_modrm, fld_w_present, fld_w, fld_req} = {p, o, m, wp, w, 1'b1};
    @(negedge clk);
    fld_req = 1'b0;
    chk(fld_done_reg, 1);
    chk(gpr_sel_reg, es);
    chk(gpr_size_reg, ez);
    @(negedge clk);
  endtask
  task seg(input logic wd, input logic [2:0] f, es, input logic ei);
    {seg_wide, seg_field, seg_req} = {wd, f, 1'b1};
    @(negedge clk);
    seg_req = 1'b0;
    chk(seg_done_reg, 1);
    chk(seg_sel_reg, es);
    chk(seg_invalid_reg, ei);
    @(negedge clk);
  endtask
  task wr(input logic [1:0] sz, input logic [31:0] exp);
    {wr_size, wr_old, wr_data, wr_req} = {sz, 32'h11223344, 32'h556677AB, 1'b1};
    @(negedge clk);
    wr_req = 1'b0;
    chk(wr_done_reg, 1);
    chk(wr_merged_reg, exp);
    @(negedge clk);
  endtask
  // *****
  // Tests
  // *****
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    #200000;
    fail_count++;
    report_and_stop;
  end
  initial
  begin
    {reset_n, clk_en, code_seg_d, real_mode, v86_mode, fld_req, seg_req, wr_req} = 8'h40;
    {fld_opcode, fld_modrm, fld_pos, fld_w_present, fld_w, seg_wide, seg_field} = 24'h000000;
    {wr_size, wr_old, wr_data} = 66'h0;
    fail_count = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    instr(0, 0, 0, 8'h00, 8'h00, 0, 0);
    instr(1, 0, 0, 8'h00, 8'h00, 1, 1);
    instr(1, 0, 0, 8'h66, 8'h00, 0, 1);
    instr(1, 0, 0, 8'h67, 8'h00, 1, 0);
    instr(0, 0, 0, 8'h66, 8'h67, 1, 1);
    instr(0, 0, 0, 8'h67, 8'h66, 1, 1);
    instr(0, 0, 0, 8'h66, 8'h66, 1, 0);
    instr(0, 0, 0, 8'h00, 8'h00, 0, 0);
    instr(1, 1, 0, 8'h00, 8'h00, 0, 0);
    instr(1, 0, 1, 8'h66, 8'h00, 1, 0);
    instr(1, 1, 0, 8'h67, 8'h00, 0, 1);
    instr(1, 0, 0, 8'h00, 8'h00, 1, 1);
    fld(2'h0, 8'h93, 8'h00, 0, 0, 3'h3, 2'h3);
    fld(2'h1, 8'h00, 8'h20, 1, 0, 3'h0, 2'h1);
    fld(2'h2, 8'h00, 8'hC6, 1, 0, 3'h2, 2'h1);
    fld(2'h2, 8'h00, 8'hC1, 1, 0, 3'h1, 2'h0);
    fld(2'h1, 8'h00, 8'h38, 1, 1, 3'h7, 2'h3);
    instr(0, 0, 0, 8'h00, 8'h00, 0, 0);
    fld(2'h2, 8'h00, 8'hC5, 1, 1, 3'h5, 2'h2);
    fld(2'h1, 8'h00, 8'h30, 0, 0, 3'h6, 2'h2);
    for (int i = 0; i < 8; i++) seg(1'b1, i[2:0], (i < 6) ? i[2:0] : 3'h0, i >= 6);
    for (int i = 0; i < 4; i++) seg(1'b0, {1'b1, i[1:0]}, {1'b0, i[1:0]}, 1'b0);
    wr(2'h0, 32'h112233AB);
    wr(2'h1, 32'h1122AB44);
    wr(2'h2, 32'h112277AB);
    wr(2'h3, 32'h556677AB);
    // Clock enable low: a write request must leave wr_done_reg and wr_merged_reg frozen
    clk_en = 1'b0;
    {wr_size, wr_req} = {2'h0, 1'b1};
    @(negedge clk);
    wr_req = 1'b0;
    chk(wr_done_reg, 0);
    chk(wr_merged_reg, 32'h556677AB);
    clk_en = 1'b1;
    report_and_stop;
  end
endmodule // tb
bind operand_size_and_field_decoder field_decoder_asserts field_decoder_asserts_i (.clk,
  .reset_n, .clk_en, .byte_valid, .byte_in, .other_prefix, .fld_req, .fld_w_present, .fld_w,
  .seg_req, .seg_wide, .seg_field, .wr_req, .wr_size, .wr_old, .size_valid_reg, .op32_reg,
  .fld_done_reg, .gpr_sel_reg, .gpr_size_reg, .seg_done_reg, .seg_sel_reg, .seg_invalid_reg,
  .wr_merged_reg);
